// ---- core/tec_pkg.sv ----
// package: register map, field positions and constants of the timer event counter
package tec_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_MODE = 8'h00;
   localparam logic [7:0] ADDR_CCTL = 8'h04;
   localparam logic [7:0] ADDR_PRM = 8'h08;
   localparam logic [7:0] ADDR_OCTL = 8'h0c;
   localparam logic [7:0] ADDR_CMP0 = 8'h10;
   localparam logic [7:0] ADDR_CMP1 = 8'h14;
   localparam logic [7:0] ADDR_CNT = 8'h18;
   localparam logic [7:0] ADDR_STAT = 8'h1c;
   localparam logic [7:0] ADDR_MASK = 8'h20;
   // field positions
   localparam int RUN_LO = 2;
   localparam int RUN_HI = 3;
   localparam int OVF_BIT = 0;
   localparam int CAP_SEL_BIT = 0;
   localparam int EDGE_LO = 4;
   localparam int EDGE_HI = 5;
   localparam int CLK_LO = 0;
   localparam int CLK_HI = 1;
   localparam int OE_BIT = 0;
   localparam int TOG_BIT = 1;
   localparam int OSP_SW_BIT = 6;
   localparam int OSP_EN_BIT = 5;
   localparam int OSP_EXT_BIT = 4;
   // status bits
   localparam int ST_M0 = 0;
   localparam int ST_M1 = 1;
   localparam int ST_OVF = 2;
   // run modes
   localparam logic [1:0] RUN_STOP = 2'h0;
   localparam logic [1:0] RUN_FREE = 2'h1;
   localparam logic [1:0] RUN_CLEAR = 2'h3;
   // edge select encodings
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   // count clock source
   localparam logic [1:0] CLK_EVENT = 2'h3;
   // event sampling divider
   localparam int SAMPLE_DIV = 4;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;
   typedef enum logic [1:0] {
      OSP_IDLE = 2'b00,
      OSP_WAIT = 2'b01,
      OSP_ACT = 2'b10
   } tec_osp_e;
endpackage : tec_pkg

// ---- core/tec_edge_filter.sv ----
// module: synchroniser, quarter-rate sampler and two-sample edge filter
`timescale 1ns/1ps
`default_nettype none
module tec_edge_filter (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // sampling enable and edge mode
   input wire logic sampleEn,
   input wire logic [1:0] edgeSel,
   // pin and result
   input wire logic pinIn,
   output logic edgeValid
);
   logic sync1_r;
   logic sync2_r;
   logic samp1_r;
   logic samp2_r;
   logic level_r;
   always_ff @(posedge clk) begin
      if (srst) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= pinIn;
         sync2_r <= sync1_r;
      end
   end
   // new level must appear on two consecutive samples before it counts
   always_ff @(posedge clk) begin
      if (srst) begin
         samp1_r <= 1'b0;
         samp2_r <= 1'b0;
         level_r <= 1'b0;
         edgeValid <= 1'b0;
      end else begin
         edgeValid <= 1'b0;
         if (sampleEn) begin
            samp1_r <= sync2_r;
            samp2_r <= samp1_r;
            if (samp1_r == samp2_r && samp1_r != level_r) begin
               level_r <= samp1_r;
               case (edgeSel)
                  tec_pkg::EDGE_FALL: edgeValid <= ~samp1_r;
                  tec_pkg::EDGE_RISE: edgeValid <= samp1_r;
                  tec_pkg::EDGE_BOTH: edgeValid <= 1'b1;
                  default: edgeValid <= 1'b0;
               endcase
            end
         end
      end
   end
endmodule : tec_edge_filter
`default_nettype wire

// ---- core/tec_timer_channel.sv ----
// module: sixteen-bit timer channel with event count, square wave and one-shot modes
// ==========================================================================
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tec_timer_channel #(
   parameter int CHANNEL = 4,
   parameter int CNT_W = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pins
   input wire logic eventInputPin,
   input wire logic oneShotTriggerPin,
   output logic timerOutputPin,
   output logic timerOutputEn,
   // interrupt requests
   output logic firstMatchIrq,
   output logic secondMatchIrq,
   output logic irq
);
   // ========================================================================
   // registers
   localparam bit HAS_OSP = (CHANNEL == 0) || (CHANNEL == 1) || (CHANNEL == 4)
      || (CHANNEL == 5);
   localparam bit OUT_SHARED = (CHANNEL <= 3);
   localparam logic [CNT_W-1:0] CNT_ZERO_W = '0;
   localparam logic [CNT_W-1:0] CNT_ONE_W = CNT_W'(1);
   localparam logic [CNT_W-1:0] CNT_MAX_W = '1;
   logic [7:0] timerModeCtrl_r;
   logic [7:0] captureCompareCtrl_r;
   logic [7:0] prescalerModeReg_r;
   logic [7:0] outputCtrlReg_r;
   logic [CNT_W-1:0] firstCompareReg_r;
   logic [CNT_W-1:0] secondCompareReg_r;
   logic [CNT_W-1:0] upCounter_r;
   logic [2:0] status_r;
   logic [2:0] mask_r;
   logic [1:0] div_r;
   logic sampleEn;
   logic eventEdge;
   logic trigEdge;
   logic swTrig;
   logic [1:0] runMode;
   logic running;
   logic countEn;
   logic match0;
   logic match1;
   logic restart;
   logic wrEn;
   logic rdEn;
   logic [2:0] evSet;
   tec_pkg::tec_osp_e osp_r;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      hit = (a == b);
   endfunction : hit

   // one decode shared by the error flag and the refused-write data clear
   function automatic logic mapped(input logic [7:0] a);
      mapped = hit(a, tec_pkg::ADDR_MODE) || hit(a, tec_pkg::ADDR_CCTL)
         || hit(a, tec_pkg::ADDR_PRM) || hit(a, tec_pkg::ADDR_OCTL)
         || hit(a, tec_pkg::ADDR_CMP0) || hit(a, tec_pkg::ADDR_CMP1)
         || hit(a, tec_pkg::ADDR_CNT) || hit(a, tec_pkg::ADDR_STAT)
         || hit(a, tec_pkg::ADDR_MASK);
   endfunction : mapped

   assign wrEn = psel && penable && pwrite;
   assign rdEn = psel && !penable && !pwrite;
   assign runMode = {timerModeCtrl_r[tec_pkg::RUN_HI], timerModeCtrl_r[tec_pkg::RUN_LO]};
   assign running = (runMode != tec_pkg::RUN_STOP);
   assign swTrig = wrEn && hit(paddr, tec_pkg::ADDR_OCTL) && pwdata[tec_pkg::OSP_SW_BIT];

   // ========================================================================
   // quarter-rate sample enable and edge filters
   always_ff @(posedge clk) begin
      if (srst) begin
         div_r <= 2'h0;
      end else begin
         div_r <= div_r + 2'h1;
      end
   end
   assign sampleEn = (div_r == 2'(tec_pkg::SAMPLE_DIV - 1));

   tec_edge_filter u_event_filter (
      .clk(clk),
      .srst(srst),
      .sampleEn(sampleEn),
      .edgeSel(prescalerModeReg_r[tec_pkg::EDGE_HI:tec_pkg::EDGE_LO]),
      .pinIn(eventInputPin),
      .edgeValid(eventEdge)
   );
   // trigger pin reuses the same edge selection
   tec_edge_filter u_trig_filter (
      .clk(clk),
      .srst(srst),
      .sampleEn(sampleEn),
      .edgeSel(prescalerModeReg_r[tec_pkg::EDGE_HI:tec_pkg::EDGE_LO]),
      .pinIn(oneShotTriggerPin),
      .edgeValid(trigEdge)
   );

   // event pin clocks the counter, otherwise the internal clock does
   assign countEn = running && ((prescalerModeReg_r[tec_pkg::CLK_HI:tec_pkg::CLK_LO]
      == tec_pkg::CLK_EVENT) ? eventEdge : 1'b1);
   assign match0 = countEn && !captureCompareCtrl_r[tec_pkg::CAP_SEL_BIT]
      && (upCounter_r == firstCompareReg_r);
   assign match1 = countEn && (upCounter_r == secondCompareReg_r);
   // trigger ignored while a pulse is running
   assign restart = HAS_OSP && running && outputCtrlReg_r[tec_pkg::OSP_EN_BIT]
      && (osp_r == tec_pkg::OSP_IDLE)
      && (swTrig || (outputCtrlReg_r[tec_pkg::OSP_EXT_BIT] && trigEdge));

   // ========================================================================
   // counter
   always_ff @(posedge clk) begin
      if (srst) begin
         upCounter_r <= CNT_ZERO_W;
      end else if (!running) begin
         upCounter_r <= CNT_ZERO_W;
      end else if (restart) begin
         upCounter_r <= CNT_ZERO_W;
      end else if (match0 && runMode == tec_pkg::RUN_CLEAR) begin
         upCounter_r <= CNT_ZERO_W;
      end else if (countEn) begin
         upCounter_r <= upCounter_r + CNT_ONE_W;
      end
   end

   // ========================================================================
   // one-shot sequencer
   always_ff @(posedge clk) begin
      if (srst) begin
         osp_r <= tec_pkg::OSP_IDLE;
      end else if (!running || !HAS_OSP) begin
         osp_r <= tec_pkg::OSP_IDLE;
      end else begin
         case (osp_r)
            tec_pkg::OSP_IDLE: if (restart) osp_r <= tec_pkg::OSP_WAIT;
            tec_pkg::OSP_WAIT: if (match0 || match1) osp_r <= tec_pkg::OSP_ACT;
            tec_pkg::OSP_ACT: if (match0 || match1) osp_r <= tec_pkg::OSP_IDLE;
            default: osp_r <= tec_pkg::OSP_IDLE;
         endcase
      end
   end

   // ========================================================================
   // output pin; shared pins of low channels are lost in event count mode
   always_ff @(posedge clk) begin
      if (srst) begin
         timerOutputPin <= 1'b0;
         timerOutputEn <= 1'b0;
      end else begin
         timerOutputEn <= outputCtrlReg_r[tec_pkg::OE_BIT] && !(OUT_SHARED
            && prescalerModeReg_r[tec_pkg::CLK_HI:tec_pkg::CLK_LO] == tec_pkg::CLK_EVENT
            && running);
         if (!running) begin
            timerOutputPin <= 1'b0;
         end else if (osp_r != tec_pkg::OSP_IDLE) begin
            if (osp_r == tec_pkg::OSP_WAIT && (match0 || match1)) timerOutputPin <= 1'b1;
            if (osp_r == tec_pkg::OSP_ACT && (match0 || match1)) timerOutputPin <= 1'b0;
         end else if (match0 && outputCtrlReg_r[tec_pkg::OE_BIT]
               && outputCtrlReg_r[tec_pkg::TOG_BIT]) begin
            timerOutputPin <= ~timerOutputPin;
         end
      end
   end

   // ========================================================================
   // match pulses and sticky status
   assign evSet[tec_pkg::ST_M0] = match0;
   assign evSet[tec_pkg::ST_M1] = match1;
   assign evSet[tec_pkg::ST_OVF] = countEn && (upCounter_r == CNT_MAX_W);

   always_ff @(posedge clk) begin
      if (srst) begin
         firstMatchIrq <= 1'b0;
         secondMatchIrq <= 1'b0;
      end else begin
         firstMatchIrq <= match0;
         secondMatchIrq <= match1;
      end
   end

   // set wins over a write-one clear
   always_ff @(posedge clk) begin
      if (srst) begin
         status_r <= 3'h0;
      end else if (wrEn && hit(paddr, tec_pkg::ADDR_STAT)) begin
         status_r <= (status_r & ~pwdata[2:0]) | evSet;
      end else begin
         status_r <= status_r | evSet;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_r & mask_r);
      end
   end

   // ========================================================================
   // register writes
   always_ff @(posedge clk) begin
      if (srst) begin
         timerModeCtrl_r <= 8'h00;
         captureCompareCtrl_r <= 8'h00;
         prescalerModeReg_r <= 8'h00;
         outputCtrlReg_r <= 8'h00;
         firstCompareReg_r <= CNT_ZERO_W;
         secondCompareReg_r <= CNT_ZERO_W;
         mask_r <= 3'h0;
      end else begin
         if (wrEn) begin
            if (hit(paddr, tec_pkg::ADDR_MODE)) begin
               timerModeCtrl_r <= {4'h0, pwdata[3:1], 1'b0};
            end else if (hit(paddr, tec_pkg::ADDR_CCTL)) begin
               captureCompareCtrl_r <= pwdata[7:0];
            end else if (hit(paddr, tec_pkg::ADDR_PRM)) begin
               prescalerModeReg_r <= pwdata[7:0];
            end else if (hit(paddr, tec_pkg::ADDR_OCTL)) begin
               // software trigger bit is a strobe and reads back zero
               outputCtrlReg_r <= pwdata[7:0] & 8'hbf;
            end else if (hit(paddr, tec_pkg::ADDR_CMP0)) begin
               firstCompareReg_r <= pwdata[CNT_W-1:0];
            end else if (hit(paddr, tec_pkg::ADDR_CMP1)) begin
               secondCompareReg_r <= pwdata[CNT_W-1:0];
            end else if (hit(paddr, tec_pkg::ADDR_MASK)) begin
               mask_r <= pwdata[2:0];
            end
         end
         // overflow flag mirrors status overflow bit
         timerModeCtrl_r[tec_pkg::OVF_BIT] <= status_r[tec_pkg::ST_OVF] | evSet[tec_pkg::ST_OVF];
      end
   end

   // ========================================================================
   // apb read path: data fetched in setup, answered in the first access cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         prdata <= tec_pkg::RD_ZERO;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            pslverr <= !mapped(paddr);
         end
         // a refused write answers with zero data as well
         if (psel && !penable && pwrite && !mapped(paddr)) begin
            prdata <= tec_pkg::RD_ZERO;
         end
         if (rdEn) begin
            if (hit(paddr, tec_pkg::ADDR_MODE)) begin
               prdata <= {24'h0, timerModeCtrl_r};
            end else if (hit(paddr, tec_pkg::ADDR_CCTL)) begin
               prdata <= {24'h0, captureCompareCtrl_r};
            end else if (hit(paddr, tec_pkg::ADDR_PRM)) begin
               prdata <= {24'h0, prescalerModeReg_r};
            end else if (hit(paddr, tec_pkg::ADDR_OCTL)) begin
               prdata <= {24'h0, outputCtrlReg_r};
            end else if (hit(paddr, tec_pkg::ADDR_CMP0)) begin
               prdata <= 32'(firstCompareReg_r);
            end else if (hit(paddr, tec_pkg::ADDR_CMP1)) begin
               prdata <= 32'(secondCompareReg_r);
            end else if (hit(paddr, tec_pkg::ADDR_CNT)) begin
               prdata <= 32'(upCounter_r);
            end else if (hit(paddr, tec_pkg::ADDR_STAT)) begin
               prdata <= {29'h0, status_r};
            end else if (hit(paddr, tec_pkg::ADDR_MASK)) begin
               prdata <= {29'h0, mask_r};
            end else begin
               prdata <= tec_pkg::RD_ZERO;
            end
         end
      end
   end
endmodule : tec_timer_channel
`default_nettype wire

// ---- test/tec_pulse_src.sv ----
// partner model: external pulse source that drives a filtered input pin of the channel
`timescale 1ns/1ps
`default_nettype none
module tec_pulse_src (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // command from the bench
   input wire logic go,
   input wire logic [3:0] edges,
   input wire logic [7:0] halfLen,
   // pin and status
   output logic pinOut,
   output logic busy
);
   // ==========================================================================
   // edge generator
   logic [3:0] left_r;
   logic [7:0] hold_r;
   // each level is held halfLen+1 cycles, so short settings make glitches
   always_ff @(posedge clk) begin
      if (srst) begin
         pinOut <= 1'b0;
         left_r <= 4'h0;
         hold_r <= 8'h00;
      end else if (go && left_r == 4'h0) begin
         left_r <= edges;
         hold_r <= halfLen;
      end else if (left_r != 4'h0) begin
         if (hold_r == 8'h00) begin
            pinOut <= ~pinOut;
            left_r <= left_r - 4'h1;
            hold_r <= halfLen;
         end else begin
            hold_r <= hold_r - 8'h01;
         end
      end
   end
   assign busy = go || (left_r != 4'h0);
endmodule : tec_pulse_src
`default_nettype wire

// ---- test/tec_timer_channel_properties.sv ----
// checker: port-level properties of the timer event counter channel
`timescale 1ns/1ps
`default_nettype none
module tec_timer_channel_properties #(
   parameter int CHANNEL = 4,
   parameter int CNT_W = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pins and requests
   input wire logic eventInputPin,
   input wire logic oneShotTriggerPin,
   input wire logic timerOutputPin,
   input wire logic timerOutputEn,
   input wire logic firstMatchIrq,
   input wire logic secondMatchIrq,
   input wire logic irq
);
   // ==========================================================================
   // properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   logic maskWr;
   assign maskWr = psel && penable && pwrite && (paddr == tec_pkg::ADDR_MASK);
   a_ready_access: assert property (psel && !penable |=> pready)
      else $error("no ready in first access cycle");
   a_ready_only: assert property (pready |-> psel && penable)
      else $error("ready outside an access phase");
   a_err_unmapped: assert property (pready && paddr > tec_pkg::ADDR_MASK |-> pslverr)
      else $error("unmapped access not refused");
   a_err_mapped: assert property (pready && paddr <= tec_pkg::ADDR_MASK && paddr[1:0] == 2'h0
      |-> !pslverr) else $error("mapped access refused");
   a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
      else $error("refused access returned data");
   a_single_first: assert property (firstMatchIrq |=> !firstMatchIrq)
      else $error("first match request wider than one cycle");
   a_single_second: assert property (secondMatchIrq |=> !secondMatchIrq)
      else $error("second match request wider than one cycle");
   a_irq_cause: assert property ($rose(irq) |-> $past(firstMatchIrq) || $past(firstMatchIrq, 2)
      || $past(secondMatchIrq) || $past(secondMatchIrq, 2) || $past(maskWr) || $past(maskWr, 2))
      else $error("interrupt rose without event or mask write");
   a_reset_quiet: assert property (@(posedge clk) disable iff (1'b0)
      srst |=> !timerOutputEn && !timerOutputPin && !irq && !firstMatchIrq)
      else $error("outputs active after reset");
   c_first: cover property (firstMatchIrq);
   c_refused: cover property (pslverr);
   c_out_rise: cover property ($rose(timerOutputPin));
   c_irq: cover property ($rose(irq));
endmodule : tec_timer_channel_properties
bind tec_timer_channel tec_timer_channel_properties #(.CHANNEL(CHANNEL), .CNT_W(CNT_W)) u_props (
   .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .eventInputPin(eventInputPin), .oneShotTriggerPin(oneShotTriggerPin),
   .timerOutputPin(timerOutputPin), .timerOutputEn(timerOutputEn),
   .firstMatchIrq(firstMatchIrq), .secondMatchIrq(secondMatchIrq), .irq(irq));
`default_nettype wire

// ---- test/testbench.sv ----
// testbench: self-checking run of the timer event counter channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module testbench;
   logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, evPin, trPin, outPin, outEn, m0Irq, m1Irq, irq, err;
   logic evGo = 1'b0, trGo = 1'b0, evBusy, trBusy;
   logic [3:0] nEdges = 4'h0;
   logic [7:0] halfLen = 8'h0c;
   int failures = 0, checks = 0, m0Count = 0, w;
   always #2.5 clk = ~clk;
   always @(posedge clk) if (m0Irq === 1'b1) m0Count++;
   tec_timer_channel #(.CHANNEL(4)) u_tec_timer_channel (.clk(clk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .eventInputPin(evPin), .oneShotTriggerPin(trPin),
      .timerOutputPin(outPin), .timerOutputEn(outEn), .firstMatchIrq(m0Irq),
      .secondMatchIrq(m1Irq), .irq(irq));
   tec_pulse_src u_ev_src (.clk(clk), .srst(srst), .go(evGo), .edges(nEdges),
      .halfLen(halfLen), .pinOut(evPin), .busy(evBusy));
   tec_pulse_src u_tr_src (.clk(clk), .srst(srst), .go(trGo), .edges(nEdges),
      .halfLen(halfLen), .pinOut(trPin), .busy(trBusy));
   // ==========================================================================
   // bus and pin helpers
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic pulses(input logic trig, input logic [3:0] n, input logic [7:0] h);
      nEdges <= n;
      halfLen <= h;
      if (trig) trGo <= 1'b1; else evGo <= 1'b1;
      @(posedge clk);
      evGo <= 1'b0;
      trGo <= 1'b0;
      while (evBusy || trBusy) @(posedge clk);
      // covers sync, quarter-rate sampling and two-sample acceptance
      repeat (40) @(posedge clk);
   endtask : pulses
   task automatic pulse_width;
      w = 0;
      while (outPin !== 1'b1) @(posedge clk);
      while (outPin === 1'b1) begin
         @(posedge clk);
         w++;
      end
   endtask : pulse_width
   // ==========================================================================
   // scenarios
   task automatic t_regs;
      apb(1'b0, tec_pkg::ADDR_CNT, 32'h0);
      `CHK(q, 32'h0000_0000)
      apb(1'b1, 8'h40, 32'hffff_ffff);
      `CHK({err, q}, {1'b1, 32'h0000_0000})
   endtask : t_regs
   task automatic t_event;
      logic [1:0] es [3] = '{tec_pkg::EDGE_RISE, tec_pkg::EDGE_FALL, tec_pkg::EDGE_BOTH};
      logic [31:0] cnt [3] = '{32'h2, 32'h1, 32'h3};
      int c;
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, tec_pkg::ADDR_CCTL, 32'h0);
         apb(1'b1, tec_pkg::ADDR_PRM, {26'h0, es[i], 2'h0, tec_pkg::CLK_EVENT});
         apb(1'b1, tec_pkg::ADDR_CMP0, 32'h8);
         apb(1'b1, tec_pkg::ADDR_MODE, {28'h0, tec_pkg::RUN_CLEAR, 2'h0});
         pulses(1'b0, 4'h3, 8'h0c);
         apb(1'b0, tec_pkg::ADDR_CNT, 32'h0);
         `CHK(q, cnt[i])
         apb(1'b1, tec_pkg::ADDR_MODE, 32'h0);
         apb(1'b0, tec_pkg::ADDR_CNT, 32'h0);
         `CHK(q, 32'h0)
         pulses(1'b0, 4'h1, 8'h0c);
      end
      apb(1'b1, tec_pkg::ADDR_CMP0, 32'h3);
      apb(1'b1, tec_pkg::ADDR_MODE, {28'h0, tec_pkg::RUN_CLEAR, 2'h0});
      pulses(1'b0, 4'h2, 8'h02);
      pulses(1'b0, 4'h2, 8'h0c);
      apb(1'b0, tec_pkg::ADDR_CNT, 32'h0);
      `CHK(q, 32'h2)
      c = m0Count;
      pulses(1'b0, 4'h2, 8'h0c);
      `CHK(m0Count - c, 1)
      apb(1'b0, tec_pkg::ADDR_CNT, 32'h0);
      `CHK(q, 32'h0)
      apb(1'b0, tec_pkg::ADDR_STAT, 32'h0);
      `CHK({irq, q[tec_pkg::ST_M0]}, 2'b01)
      apb(1'b1, tec_pkg::ADDR_MASK, 32'h1);
      repeat (3) @(posedge clk);
      `CHK(irq, 1'b1)
      apb(1'b1, tec_pkg::ADDR_STAT, 32'h1);
      repeat (3) @(posedge clk);
      `CHK(irq, 1'b0)
      apb(1'b1, tec_pkg::ADDR_MODE, 32'h0);
   endtask : t_event
   task automatic t_square;
      apb(1'b1, tec_pkg::ADDR_PRM, 32'h0);
      apb(1'b1, tec_pkg::ADDR_CCTL, 32'h0);
      apb(1'b1, tec_pkg::ADDR_OCTL, 32'h3);
      apb(1'b1, tec_pkg::ADDR_CMP0, 32'h5);
      apb(1'b1, tec_pkg::ADDR_MODE, {28'h0, tec_pkg::RUN_CLEAR, 2'h0});
      pulse_width();
      `CHK(w, 6)
      `CHK(outEn, 1'b1)
      apb(1'b1, tec_pkg::ADDR_MODE, 32'h0);
   endtask : t_square
   task automatic t_oneshot;
      apb(1'b1, tec_pkg::ADDR_PRM, {26'h0, tec_pkg::EDGE_RISE, 4'h0});
      apb(1'b1, tec_pkg::ADDR_OCTL, 32'h21);
      apb(1'b1, tec_pkg::ADDR_CMP0, 32'ha);
      apb(1'b1, tec_pkg::ADDR_CMP1, 32'h4);
      apb(1'b1, tec_pkg::ADDR_MODE, {28'h0, tec_pkg::RUN_FREE, 2'h0});
      apb(1'b1, tec_pkg::ADDR_OCTL, 32'h61);
      pulse_width();
      `CHK(w, 6)
      apb(1'b1, tec_pkg::ADDR_OCTL, 32'h31);
      fork
         pulses(1'b1, 4'h1, 8'h0c);
         pulse_width();
      join
      `CHK(w, 6)
      apb(1'b1, tec_pkg::ADDR_MODE, 32'h0);
   endtask : t_oneshot
   task automatic results;
      if (failures == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : results
   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_event();
      t_square();
      t_oneshot();
      results();
   end
   initial begin
      repeat (40000) @(posedge clk);
      failures++;
      results();
   end
endmodule : testbench
`default_nettype wire
